// file: common/blcfg_pkg.sv
// blcfg_pkg: constants and carriers for the backlight config/boost/brightness register bank
package blcfg_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BLCFG_OFS_CTRL   = 8'h00;
  localparam logic [7:0] BLCFG_OFS_CONFIG = 8'h01;
  localparam logic [7:0] BLCFG_OFS_BOOST  = 8'h02;
  localparam logic [7:0] BLCFG_OFS_BRT_A  = 8'h03;
  localparam logic [7:0] BLCFG_OFS_BRT_B  = 8'h04;

  // ----------------------------------------------------------------
  // reset values, writable masks and minimum brightness code
  // ----------------------------------------------------------------
  localparam logic [7:0] BLCFG_RST_CONFIG  = 8'h18;
  localparam logic [7:0] BLCFG_RST_BOOST   = 8'h38;
  localparam logic [7:0] BLCFG_RST_BRT     = 8'h00;
  localparam logic [7:0] BLCFG_MASK_CONFIG = 8'h1F;
  localparam logic [7:0] BLCFG_MASK_BOOST  = 8'h7F;
  localparam logic [7:0] BLCFG_BRT_MIN     = 8'h04;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BLCFG_CFG_PWM_A   = 0;
  localparam int BLCFG_CFG_PWM_B   = 1;
  localparam int BLCFG_CFG_PWM_LOW = 2;
  localparam int BLCFG_CFG_FB_A    = 3;
  localparam int BLCFG_CFG_FB_B    = 4;
  localparam int BLCFG_BST_BAND    = 0;
  localparam int BLCFG_BST_SHIFT   = 1;
  localparam int BLCFG_BST_SLOW    = 2;
  localparam int BLCFG_BST_OCP_LO  = 3;
  localparam int BLCFG_BST_OVP_LO  = 5;
  localparam int BLCFG_CTRL_SLEEP  = 6;

  // ----------------------------------------------------------------
  // oscillator selections in kHz
  // ----------------------------------------------------------------
  localparam logic [11:0] BLCFG_F_LO_KHZ  = 12'd500;
  localparam logic [11:0] BLCFG_F_LOS_KHZ = 12'd560;
  localparam logic [11:0] BLCFG_F_HI_KHZ  = 12'd1000;
  localparam logic [11:0] BLCFG_F_HIS_KHZ = 12'd1120;

  // over-voltage threshold in volts, over-current limit in mA
  localparam logic [5:0]  BLCFG_OVP_V [4]  = '{6'd16, 6'd24, 6'd32, 6'd40};
  localparam logic [10:0] BLCFG_OCP_MA [4] = '{11'd600, 11'd800, 11'd1000, 11'd1200};

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } blcfg_req_t;

  typedef struct packed {
    logic        pwm_en_a;
    logic        pwm_en_b;
    logic        pwm_active_low;
    logic        bank_a_feedback_on;
    logic        bank_b_feedback_on;
    logic [5:0]  ovp_volts;
    logic [10:0] ocp_ma;
    logic [11:0] osc_khz;
    logic        slow_start;
    logic [7:0]  brt_a;
    logic [7:0]  brt_b;
  } blcfg_ctl_t;

endpackage : blcfg_pkg

// file: rtl/blcfg_regs.sv
// blcfg_regs: configuration, boost and brightness registers of the backlight driver
`timescale 1ns/1ps
module blcfg_regs (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // register access from the serial engine
  input  wire blcfg_pkg::blcfg_req_t req,
  output logic [7:0]             rdata,
  output logic                   rd_hit,
  // sleep state from the control logic
  input  wire logic              sleep_status,
  // decoded controls toward the analog and dimming logic
  output blcfg_pkg::blcfg_ctl_t  ctl,
  // raw register images
  output logic [7:0]             config_q,
  output logic [7:0]             boost_q
);
  import blcfg_pkg::*;

  logic [7:0] config_r;
  logic [7:0] boost_r;
  logic [7:0] brt_a_r;
  logic [7:0] brt_b_r;
  logic [7:0] rdata_r;
  logic       rd_hit_r;
  logic [7:0] ctrl_img;

  // write strobe decode, shared by all registers
  function automatic logic wr_hit(input blcfg_req_t r, input logic [7:0] ofs);
    wr_hit = r.wr_en && (r.addr == ofs);
  endfunction : wr_hit

  // oscillator choice from band and shift
  function automatic logic [11:0] osc_sel(input logic band, input logic shift);
    case ({band, shift})
      2'b00:   osc_sel = BLCFG_F_LO_KHZ;
      2'b01:   osc_sel = BLCFG_F_LOS_KHZ;
      2'b10:   osc_sel = BLCFG_F_HI_KHZ;
      default: osc_sel = BLCFG_F_HIS_KHZ;
    endcase
  endfunction : osc_sel

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  // upper bits masked off so they always read zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      config_r <= BLCFG_RST_CONFIG;
    end else if (wr_hit(req, BLCFG_OFS_CONFIG)) begin
      config_r <= req.wdata & BLCFG_MASK_CONFIG;
    end
  end

  // ----------------------------------------------------------------
  // boost register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      boost_r <= BLCFG_RST_BOOST;
    end else if (wr_hit(req, BLCFG_OFS_BOOST)) begin
      boost_r <= req.wdata & BLCFG_MASK_BOOST;
    end
  end

  // ----------------------------------------------------------------
  // brightness registers
  // ----------------------------------------------------------------
  // sleep freezes both; the write is dropped, not deferred
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      brt_a_r <= BLCFG_RST_BRT;
      brt_b_r <= BLCFG_RST_BRT;
    end else if (!sleep_status) begin
      if (wr_hit(req, BLCFG_OFS_BRT_A)) begin
        brt_a_r <= req.wdata;
      end
      if (wr_hit(req, BLCFG_OFS_BRT_B)) begin
        brt_b_r <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data registered one cycle after rd_en; unmapped offsets return zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_r  <= 8'h00;
      rd_hit_r <= 1'b0;
    end else begin
      rd_hit_r <= 1'b0;
      if (req.rd_en) begin
        rd_hit_r <= 1'b1;
        case (req.addr)
          BLCFG_OFS_CTRL:   rdata_r <= ctrl_img;
          BLCFG_OFS_CONFIG: rdata_r <= config_r;
          BLCFG_OFS_BOOST:  rdata_r <= boost_r;
          BLCFG_OFS_BRT_A:  rdata_r <= brt_a_r;
          BLCFG_OFS_BRT_B:  rdata_r <= brt_b_r;
          default:          rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  // straight from flops; no extra latency added
  always_comb begin
    ctl                = '0;
    ctl.pwm_en_a       = config_r[BLCFG_CFG_PWM_A];
    ctl.pwm_en_b       = config_r[BLCFG_CFG_PWM_B];
    ctl.pwm_active_low = config_r[BLCFG_CFG_PWM_LOW];
    ctl.bank_a_feedback_on = config_r[BLCFG_CFG_FB_A];
    ctl.bank_b_feedback_on = config_r[BLCFG_CFG_FB_B];
    ctl.ovp_volts      = BLCFG_OVP_V[boost_r[BLCFG_BST_OVP_LO +: 2]];
    ctl.ocp_ma         = BLCFG_OCP_MA[boost_r[BLCFG_BST_OCP_LO +: 2]];
    ctl.osc_khz        = osc_sel(boost_r[BLCFG_BST_BAND],
                                 boost_r[BLCFG_BST_SHIFT]);
    ctl.slow_start     = boost_r[BLCFG_BST_SLOW];
    ctl.brt_a          = brt_a_r;
    ctl.brt_b          = brt_b_r;
  end

  // control image: only the sleep flag lives in this bank, the rest reads zero
  assign ctrl_img = 8'(sleep_status) << BLCFG_CTRL_SLEEP;

  assign rdata    = rdata_r;
  assign rd_hit   = rd_hit_r;
  assign config_q = config_r;
  assign boost_q  = boost_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cfg_reset;
    @(posedge clk_sys) !rst_b |=> config_r == 8'h18;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");

  property p_bst_reset;
    @(posedge clk_sys) !rst_b |=> boost_r == 8'h38;
  endproperty
  a_bst_reset: assert property (p_bst_reset) else $error("boost reset value wrong");

  property p_cfg_high_zero;
    @(posedge clk_sys) disable iff (!rst_b) config_r[7:5] == 3'b000 && boost_r[7] == 1'b0;
  endproperty
  a_cfg_high_zero: assert property (p_cfg_high_zero) else $error("unused bits set");

  property p_brt_sleep_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      sleep_status |=> $stable(brt_a_r) && $stable(brt_b_r);
  endproperty
  a_brt_sleep_hold: assert property (p_brt_sleep_hold)
    else $error("brightness changed in sleep");

  property p_brt_a_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (!sleep_status && req.wr_en && req.addr == 8'h03) |=> ctl.brt_a == $past(req.wdata);
  endproperty
  a_brt_a_write: assert property (p_brt_a_write) else $error("bank A write lost");

  property p_brt_b_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (!sleep_status && req.wr_en && req.addr == 8'h04) |=> ctl.brt_b == $past(req.wdata);
  endproperty
  a_brt_b_write: assert property (p_brt_b_write) else $error("bank B write lost");

  property p_pwm_gate;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.wr_en && req.addr == 8'h01) |=>
        ctl.pwm_en_a == $past(req.wdata[0]) && ctl.pwm_en_b == $past(req.wdata[1]) &&
        ctl.pwm_active_low == $past(req.wdata[2]);
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pwm controls wrong");

  property p_ovp_map;
    @(posedge clk_sys) disable iff (!rst_b)
      ctl.ovp_volts == 6'd16 + 6'd8 * {4'h0, boost_r[6:5]};
  endproperty
  a_ovp_map: assert property (p_ovp_map) else $error("ovp threshold wrong");

  property p_ocp_map;
    @(posedge clk_sys) disable iff (!rst_b)
      ctl.ocp_ma == 11'd600 + 11'd200 * {9'h000, boost_r[4:3]};
  endproperty
  a_ocp_map: assert property (p_ocp_map) else $error("ocp limit wrong");

  property p_osc_map;
    @(posedge clk_sys) disable iff (!rst_b)
      ctl.osc_khz == (boost_r[0] ? 12'd1000 : 12'd500) +
        (boost_r[1] ? (boost_r[0] ? 12'd120 : 12'd60) : 12'd0);
  endproperty
  a_osc_map: assert property (p_osc_map)
    else $error("oscillator select wrong");

  property p_sleep_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd_en && req.addr == 8'h00) |=> rd_hit && rdata[6] == $past(sleep_status);
  endproperty
  a_sleep_read: assert property (p_sleep_read)
    else $error("sleep status read wrong");

  // both banks come out of reset dark
  property p_brt_reset;
    @(posedge clk_sys) !rst_b |=> brt_a_r == 8'h00 && brt_b_r == 8'h00;
  endproperty
  a_brt_reset: assert property (p_brt_reset)
    else $error("brightness reset value wrong");

  // feedback enables follow their config bits with no extra latency
  property p_fb_map;
    @(posedge clk_sys) disable iff (!rst_b)
      ctl.bank_a_feedback_on == config_r[3] && ctl.bank_b_feedback_on == config_r[4];
  endproperty
  a_fb_map: assert property (p_fb_map)
    else $error("feedback enable wrong");

  // config only moves on a write to its own offset
  property p_cfg_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !(req.wr_en && req.addr == 8'h01) |=> $stable(config_r);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed without a write");

  // boost only moves on a write to its own offset
  property p_bst_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !(req.wr_en && req.addr == 8'h02) |=> $stable(boost_r);
  endproperty
  a_bst_hold: assert property (p_bst_hold)
    else $error("boost changed without a write");

  // boost write keeps the defined bits, bit 7 stays clear
  property p_bst_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.wr_en && req.addr == 8'h02) |=> boost_r == {1'b0, $past(req.wdata[6:0])};
  endproperty
  a_bst_write: assert property (p_bst_write)
    else $error("boost write lost");

  // bank A level only moves through a write to its offset
  property p_brt_a_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !(req.wr_en && req.addr == 8'h03) |=> $stable(brt_a_r);
  endproperty
  a_brt_a_hold: assert property (p_brt_a_hold)
    else $error("bank A changed without a write");

  // bank B level only moves through a write to its offset
  property p_brt_b_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      !(req.wr_en && req.addr == 8'h04) |=> $stable(brt_b_r);
  endproperty
  a_brt_b_hold: assert property (p_brt_b_hold)
    else $error("bank B changed without a write");

  // bank A read returns the level held when the read was taken
  property p_brt_a_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd_en && req.addr == 8'h03) |=> rdata == $past(brt_a_r);
  endproperty
  a_brt_a_read: assert property (p_brt_a_read)
    else $error("bank A read wrong");

  // bank B read returns the level held when the read was taken
  property p_brt_b_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd_en && req.addr == 8'h04) |=> rdata == $past(brt_b_r);
  endproperty
  a_brt_b_read: assert property (p_brt_b_read)
    else $error("bank B read wrong");

  // config read returns the stored image, upper bits clear
  property p_cfg_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd_en && req.addr == 8'h01) |=> rdata == $past(config_r) && rdata[7:5] == 3'b000;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("config read wrong");

  // control read shows the sleep flag and nothing else
  property p_ctrl_read_quiet;
    @(posedge clk_sys) disable iff (!rst_b)
      (req.rd_en && req.addr == 8'h00) |=> rdata[7] == 1'b0 && rdata[5:0] == 6'h00;
  endproperty
  a_ctrl_read_quiet: assert property (p_ctrl_read_quiet)
    else $error("control read shows stray bits");

  // every read is answered in the next cycle
  property p_rd_answer;
    @(posedge clk_sys) disable iff (!rst_b)
      req.rd_en |=> rd_hit;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");

  // no answer shows without a read behind it
  property p_rd_no_spurious;
    @(posedge clk_sys) disable iff (!rst_b)
      rd_hit |-> $past(req.rd_en);
  endproperty
  a_rd_no_spurious: assert property (p_rd_no_spurious)
    else $error("read answer without request");

  c_brt_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
    !sleep_status && req.wr_en && req.addr == 8'h03);
  c_sleep_drop: cover property (@(posedge clk_sys) disable iff (!rst_b)
    sleep_status && req.wr_en && req.addr == 8'h04);
  c_high_band_shift: cover property (@(posedge clk_sys) disable iff (!rst_b)
    boost_r[1:0] == 2'b11);
  c_pwm_low: cover property (@(posedge clk_sys) disable iff (!rst_b)
    config_r[2] && config_r[1]);
  c_sleep_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
    sleep_status && req.rd_en && req.addr == 8'h00);

endmodule : blcfg_regs

// file: dv/blcfg_host_model.sv
// blcfg_host_model: serial-engine side model issuing register writes and reads
`timescale 1ns/1ps
module blcfg_host_model (
  // clock
  input  wire logic             clk_sys,
  // request toward the register bank
  output blcfg_pkg::blcfg_req_t req,
  // read answer
  input  wire logic [7:0]       rdata,
  input  wire logic             rd_hit
);
  import blcfg_pkg::*;

  // idle bus from time zero so nothing is taken during reset
  initial req = '0;

  // one-cycle write pulse, then idle; data goes out unmasked, the bank drops undefined bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
    #1;  // let the taking edge land before anyone looks
  endtask : wr

  // one-cycle read pulse; the answer must show exactly one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_sys);
    req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    ok = (rd_hit === 1'b1);
    d  = rdata;
  endtask : rd
endmodule : blcfg_host_model

// file: dv/testbench.sv
// testbench: self-checking bench for the backlight register bank
`timescale 1ns/1ps
module testbench;
  import blcfg_pkg::*;
  logic        clk_sys      = 1'b0;
  logic        rst_b        = 1'b0;
  logic        sleep_status = 1'b0;
  blcfg_req_t  req;
  logic [7:0]  rdata;
  logic        rd_hit;
  blcfg_ctl_t  ctl;
  logic [7:0]  config_q;
  logic [7:0]  boost_q;
  int          miscompares  = 0;
  int          checked      = 0;
  int          ovp_v [4]    = '{16, 24, 32, 40};
  int          ocp_m [4]    = '{600, 800, 1000, 1200};
  int          osc_k [4]    = '{500, 1000, 560, 1120};

  // 20 MHz system clock
  initial forever #25 clk_sys = ~clk_sys;

  blcfg_regs i_blcfg_regs (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata),
    .rd_hit(rd_hit), .sleep_status(sleep_status), .ctl(ctl), .config_q(config_q),
    .boost_q(boost_q));
  blcfg_host_model i_blcfg_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata),
    .rd_hit(rd_hit));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // a missing answer counts as a mismatch; the data compare still runs
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_blcfg_host_model.rd(a, d, ok);
    check({15'h0000, ok}, 16'h0001);
    check(d, exp);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(BLCFG_OFS_CONFIG, 8'h18);
    rd_chk(BLCFG_OFS_BOOST, 8'h38);
    rd_chk(BLCFG_OFS_BRT_A, 8'h00);
    rd_chk(BLCFG_OFS_BRT_B, 8'h00);
    check({ctl.bank_b_feedback_on, ctl.bank_a_feedback_on}, 2'b11);
    check({ctl.pwm_active_low, ctl.pwm_en_b, ctl.pwm_en_a}, 3'b000);
    check({ctl.ovp_volts, ctl.slow_start}, {6'd24, 1'b0});
    check(ctl.ocp_ma, 16'd1200);
    check(ctl.osc_khz, 16'd500);
  endtask : t_reset

  // enable A on its own, then enable B with polarity, then junk in the upper bits
  task automatic t_config();
    i_blcfg_host_model.wr(BLCFG_OFS_CONFIG, 8'h01);
    check({ctl.pwm_en_b, ctl.pwm_en_a, ctl.pwm_active_low}, 3'b010);
    check(ctl.bank_a_feedback_on, 1'b0);
    i_blcfg_host_model.wr(BLCFG_OFS_CONFIG, 8'h16);
    check({ctl.pwm_en_b, ctl.pwm_en_a, ctl.pwm_active_low}, 3'b101);
    check(ctl.bank_b_feedback_on, 1'b1);
    i_blcfg_host_model.wr(BLCFG_OFS_CONFIG, 8'hFF);
    rd_chk(BLCFG_OFS_CONFIG, 8'h1F);
    check(config_q, 8'h1F);
    i_blcfg_host_model.wr(BLCFG_OFS_BOOST, 8'hFF);
    check(boost_q, 8'h7F);
    check(ctl.slow_start, 1'b1);
  endtask : t_config

  // every threshold, limit and oscillator code
  task automatic t_boost();
    for (int i = 0; i < 4; i++) begin
      i_blcfg_host_model.wr(BLCFG_OFS_BOOST, {1'b0, i[1:0], i[1:0], 3'b000});
      check(ctl.ovp_volts, 16'(ovp_v[i]));
      check(ctl.ocp_ma, 16'(ocp_m[i]));
      i_blcfg_host_model.wr(BLCFG_OFS_BOOST, {6'h00, i[1:0]});
      check(ctl.osc_khz, 16'(osc_k[i]));
    end
  endtask : t_boost

  // brightness codes kept at or above the minimum usable code
  task automatic t_bright();
    i_blcfg_host_model.wr(BLCFG_OFS_BRT_A, 8'h40);
    i_blcfg_host_model.wr(BLCFG_OFS_BRT_B, 8'h04);
    check(ctl.brt_a, 8'h40);
    check(ctl.brt_b, 8'h04);
    rd_chk(BLCFG_OFS_BRT_B, 8'h04);
    @(posedge clk_sys);
    sleep_status <= 1'b1;
    i_blcfg_host_model.wr(BLCFG_OFS_BRT_A, 8'h80);
    i_blcfg_host_model.wr(BLCFG_OFS_BRT_B, 8'hFF);
    check({ctl.brt_a, ctl.brt_b}, 16'h4004);
    rd_chk(BLCFG_OFS_CTRL, 8'h40);
    @(posedge clk_sys);
    sleep_status <= 1'b0;
    rd_chk(BLCFG_OFS_CTRL, 8'h00);
    i_blcfg_host_model.wr(BLCFG_OFS_BRT_A, 8'h80);
    rd_chk(BLCFG_OFS_BRT_A, 8'h80);
  endtask : t_bright

  // reset again mid-run; config, boost and bank A fall back to their defaults
  task automatic t_rerst();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(BLCFG_OFS_CONFIG, 8'h18);
    rd_chk(BLCFG_OFS_BOOST, 8'h38);
    rd_chk(BLCFG_OFS_BRT_A, 8'h00);
    check(boost_q, 8'h38);
  endtask : t_rerst

  // reset for four cycles, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_config();
    t_boost();
    t_bright();
    t_rerst();
    stop_test();
  end
endmodule : testbench
